// ---- ufc_pkg.sv ----
package ufc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_EFR = 5'h00;
  localparam logic [4:0] ADDR_TXLVL = 5'h01;
  localparam logic [4:0] ADDR_TXTHR = 5'h02;
  localparam logic [4:0] ADDR_RXLVL = 5'h03;
  localparam logic [4:0] ADDR_RXTHR = 5'h04;
  localparam logic [4:0] ADDR_STOP1 = 5'h05;
  localparam logic [4:0] ADDR_STOP2 = 5'h06;
  localparam logic [4:0] ADDR_RES1 = 5'h07;
  localparam logic [4:0] ADDR_RES2 = 5'h08;
  localparam logic [4:0] ADDR_FSTAT = 5'h09;
  localparam logic [4:0] ADDR_IER = 5'h0a;
  localparam logic [4:0] ADDR_FCR = 5'h0b;
  localparam logic [4:0] ADDR_MCR = 5'h0c;
  localparam logic [4:0] ADDR_MSR = 5'h0d;
  localparam logic [4:0] ADDR_FEATURE_CONTROL_REG = 5'h0e;
  localparam logic [4:0] ADDR_ISR = 5'h0f;
  localparam logic [4:0] ADDR_IRQ = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EFR_AUTO_CTS = 7;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_ENH = 4;
  localparam int MCR_SEL_DTR = 2;
  localparam int MCR_RTS_SW = 1;
  localparam int FEATURE_CONTROL_REG_RS485 = 5;
  localparam int ISR_SPECIAL = 4;
  localparam int ISR_STOPCH = 5;
  localparam int FST_TX_RES = 3;
  localparam int FST_TX_STOP = 2;
  localparam int FST_RX_RES = 1;
  localparam int FST_RX_STOP = 0;
  localparam int IRQ_TX_LOW = 0;
  localparam int IRQ_RX_TRIG = 1;

  // ----------------------------------------------------------------
  // masks, encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IER_ENH_MASK = 8'he0;
  localparam logic [7:0] ISR_ENH_MASK = 8'h30;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;
  localparam logic [7:0] MSR_ENH_MASK = 8'hff;
  localparam logic [7:0] FSTAT_MASK = 8'h0f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [8:0] LEVEL_SAT = 9'h0ff;
  localparam logic [8:0] FIFO_DEPTH = 9'h100;
  localparam logic [8:0] HYST_DEFAULT = 9'h004;
  localparam logic [1:0] SEL_NONE = 2'b00;
  localparam logic [1:0] SEL_SECOND = 2'b01;
  localparam logic [1:0] SEL_FIRST = 2'b10;
  localparam logic [1:0] SEL_BOTH = 2'b11;

  typedef enum logic [1:0] {
    TXC_IDLE = 2'b00,
    TXC_FIRST = 2'b01,
    TXC_SECOND = 2'b10
  } ufc_txc_t;

endpackage : ufc_pkg

// ---- ufc_flow.sv ----
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ufc_flow (
  // clock and reset
  input wire logic sysClk,
  input wire logic resetn,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // fifo occupancy events
  input wire logic txPush,
  input wire logic txPop,
  input wire logic rxPush,
  input wire logic rxPop,
  // receiver character path
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  output logic rxCharStore,
  // transmitter control-character path
  input wire logic txFlowNeedStop,
  input wire logic txFlowNeedResume,
  output logic txCtrlValid,
  output logic [7:0] txCtrlChar,
  input wire logic txCtrlReady,
  // transmitter status
  input wire logic txBusy,
  output logic txHalt,
  // modem lines, active low
  input wire logic ctsN,
  input wire logic dsrN,
  output logic rtsN,
  output logic dtrN,
  // events
  output logic txLowIrq,
  output logic rxTrigIrq,
  output logic rxStopSeen,
  output logic rxResumeSeen
);

  typedef struct packed {
    logic [7:0] enhanced_feature_ctrl;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] interrupt_status_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] modem_status_reg;
    logic [7:0] feature_control_reg;
    logic [8:0] txLvl;
    logic [8:0] rxLvl;
    logic [7:0] txThr;
    logic [7:0] rxThr;
    logic [7:0] stop1;
    logic [7:0] stop2;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [3:0] fstat;
    logic rxHold;
    logic rxPend;
    logic rxPendStop;
    logic rtsAuto;
    ufc_pkg::ufc_txc_t txc;
    logic txcStop;
    logic txLowLvl;
    logic rxTrigLvl;
    logic [7:0] rdata;
    logic charStore;
    logic stopSeen;
    logic resumeSeen;
  } ufc_state_t;

  ufc_state_t s_q;
  ufc_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] lvlStep(input logic [8:0] lvl, input logic inc,
                                         input logic dec);
    logic [8:0] r;
    r = lvl;
    if (inc && !dec && lvl != ufc_pkg::FIFO_DEPTH)
      r = lvl + 9'h001;
    else if (dec && !inc && lvl != 9'h000)
      r = lvl - 9'h001;
    return r;
  endfunction : lvlStep

  // 256 entries cannot fit eight bits, so full reads as 0xff
  function automatic logic [7:0] lvlRead(input logic [8:0] lvl);
    return (lvl > ufc_pkg::LEVEL_SAT) ? 8'hff : lvl[7:0];
  endfunction : lvlRead

  function automatic logic [7:0] gatedWrite(input logic [7:0] old, input logic [7:0] wr,
                                            input logic [7:0] mask, input logic enh);
    return enh ? wr : ((old & mask) | (wr & ~mask));
  endfunction : gatedWrite

  logic [1:0] txSel;
  logic [1:0] rxSel;
  logic swFlowOn;
  logic rs485;
  logic specialHit;
  logic isStop1;
  logic isStop2;
  logic isRes1;
  logic isRes2;
  logic pairMode;
  logic [8:0] hyst;

  assign txSel = s_q.enhanced_feature_ctrl[3:2];
  assign rxSel = s_q.enhanced_feature_ctrl[1:0];
  assign swFlowOn = (s_q.enhanced_feature_ctrl[3:0] != 4'h0);
  assign rs485 = s_q.feature_control_reg[ufc_pkg::FEATURE_CONTROL_REG_RS485];
  assign isStop1 = (rxChar == s_q.stop1);
  assign isStop2 = (rxChar == s_q.stop2);
  assign isRes1 = (rxChar == s_q.res1);
  assign isRes2 = (rxChar == s_q.res2);
  assign specialHit = s_q.enhanced_feature_ctrl[ufc_pkg::EFR_SPECIAL] && isStop2;
  // either pair with single transmit, both in sequence otherwise
  assign pairMode = (rxSel == ufc_pkg::SEL_BOTH) &&
                    (txSel == ufc_pkg::SEL_BOTH || txSel == ufc_pkg::SEL_NONE);
  assign hyst = ufc_pkg::HYST_DEFAULT;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic stopHit;
    logic resHit;
    logic firstHalf;
    logic txSend;
    logic [3:0] fstatSet;
    fstatSet = 4'h0;
    stopHit = 1'b0;
    resHit = 1'b0;
    firstHalf = 1'b0;
    txSend = 1'b0;
    s_d = s_q;
    s_d.charStore = 1'b0;
    s_d.stopSeen = 1'b0;
    s_d.resumeSeen = 1'b0;

    s_d.txLvl = lvlStep(s_q.txLvl, txPush, txPop);
    s_d.rxLvl = lvlStep(s_q.rxLvl, rxPush, rxPop);
    s_d.txLowLvl = (s_d.txLvl < {1'b0, s_q.txThr});
    s_d.rxTrigLvl = (s_d.rxLvl >= {1'b0, s_q.rxThr});

    // deassert at or above trigger plus hysteresis, reassert below minus it
    if (s_q.enhanced_feature_ctrl[ufc_pkg::EFR_AUTO_RTS] && !rs485)
    begin
      if (s_q.rxLvl >= {1'b0, s_q.rxThr} + hyst)
        s_d.rtsAuto = 1'b1;
      else if ({1'b0, s_q.rxLvl} + {1'b0, hyst} < {2'b00, s_q.rxThr})
        s_d.rtsAuto = 1'b0;
    end
    else
      s_d.rtsAuto = 1'b0;

    // receive compare
    if (rxCharValid)
    begin
      unique case (rxSel)
        ufc_pkg::SEL_NONE:
        begin
          stopHit = 1'b0;
        end
        ufc_pkg::SEL_FIRST:
        begin
          stopHit = isStop1;
          resHit = isRes1;
        end
        ufc_pkg::SEL_SECOND:
        begin
          stopHit = isStop2;
          resHit = isRes2;
        end
        ufc_pkg::SEL_BOTH:
        begin
          if (pairMode)
          begin
            if (s_q.rxPend)
            begin
              stopHit = s_q.rxPendStop && isStop2;
              resHit = !s_q.rxPendStop && isRes2;
            end
            firstHalf = isStop1 || isRes1;
          end
          else
          begin
            stopHit = isStop1 || isStop2;
            resHit = isRes1 || isRes2;
          end
        end
      endcase
      s_d.rxPend = firstHalf && !(stopHit || resHit);
      s_d.rxPendStop = isStop1;
      s_d.charStore = !(stopHit || resHit || firstHalf);
      if (specialHit)
      begin
        s_d.interrupt_status_reg[ufc_pkg::ISR_SPECIAL] = 1'b1;
        s_d.charStore = (rxSel != ufc_pkg::SEL_SECOND);
        if (rxSel == ufc_pkg::SEL_SECOND)
          s_d.interrupt_status_reg[ufc_pkg::ISR_STOPCH] = 1'b1;
      end
      if (stopHit)
      begin
        s_d.rxHold = 1'b1;
        s_d.stopSeen = 1'b1;
        s_d.fstat[ufc_pkg::FST_RX_STOP] = 1'b1;
        fstatSet[ufc_pkg::FST_RX_STOP] = 1'b1;
        s_d.fstat[ufc_pkg::FST_RX_RES] = 1'b0;
      end
      else if (resHit)
      begin
        s_d.rxHold = 1'b0;
        s_d.resumeSeen = 1'b1;
        s_d.fstat[ufc_pkg::FST_RX_RES] = 1'b1;
        fstatSet[ufc_pkg::FST_RX_RES] = 1'b1;
        s_d.fstat[ufc_pkg::FST_RX_STOP] = 1'b0;
      end
    end

    // control character sequencer
    unique case (s_q.txc)
      ufc_pkg::TXC_IDLE:
      begin
        if (txSel != ufc_pkg::SEL_NONE && (txFlowNeedStop || txFlowNeedResume))
        begin
          s_d.txc = ufc_pkg::TXC_FIRST;
          s_d.txcStop = txFlowNeedStop;
        end
      end
      ufc_pkg::TXC_FIRST:
      begin
        if (txCtrlReady)
        begin
          txSend = (txSel != ufc_pkg::SEL_BOTH);
          s_d.txc = txSend ? ufc_pkg::TXC_IDLE : ufc_pkg::TXC_SECOND;
        end
      end
      ufc_pkg::TXC_SECOND:
      begin
        if (txCtrlReady)
        begin
          txSend = 1'b1;
          s_d.txc = ufc_pkg::TXC_IDLE;
        end
      end
      default:
      begin
        s_d.txc = ufc_pkg::TXC_IDLE;
      end
    endcase
    if (txSend)
    begin
      s_d.fstat[ufc_pkg::FST_TX_STOP] = s_q.txcStop;
      s_d.fstat[ufc_pkg::FST_TX_RES] = !s_q.txcStop;
      fstatSet[ufc_pkg::FST_TX_STOP] = s_q.txcStop;
      fstatSet[ufc_pkg::FST_TX_RES] = !s_q.txcStop;
    end

    // register reads; status clears, new events set in the same cycle win
    s_d.rdata = ufc_pkg::RESET_BYTE;
    if (regRd)
    begin
      unique case (regAddr)
        ufc_pkg::ADDR_EFR: s_d.rdata = s_q.enhanced_feature_ctrl;
        ufc_pkg::ADDR_TXLVL: s_d.rdata = lvlRead(s_q.txLvl);
        ufc_pkg::ADDR_RXLVL: s_d.rdata = lvlRead(s_q.rxLvl);
        ufc_pkg::ADDR_FSTAT:
        begin
          s_d.rdata = {4'h0, s_q.fstat};
          s_d.fstat = s_d.fstat & ~(s_q.fstat & ~fstatSet);
        end
        ufc_pkg::ADDR_IER: s_d.rdata = s_q.interrupt_enable_reg;
        ufc_pkg::ADDR_FCR: s_d.rdata = s_q.fifo_control_reg;
        ufc_pkg::ADDR_MCR: s_d.rdata = s_q.modem_control_reg;
        ufc_pkg::ADDR_MSR: s_d.rdata = s_q.modem_status_reg;
        ufc_pkg::ADDR_FEATURE_CONTROL_REG: s_d.rdata = s_q.feature_control_reg;
        ufc_pkg::ADDR_ISR: s_d.rdata = s_q.interrupt_status_reg;
        ufc_pkg::ADDR_IRQ: s_d.rdata = {6'h00, s_q.rxTrigLvl, s_q.txLowLvl};
        default: s_d.rdata = ufc_pkg::RESET_BYTE;
      endcase
    end

    // register writes; thresholds and characters are write only
    if (regWr)
    begin
      unique case (regAddr)
        ufc_pkg::ADDR_EFR: s_d.enhanced_feature_ctrl = regWdata;
        ufc_pkg::ADDR_TXTHR: s_d.txThr = regWdata;
        ufc_pkg::ADDR_RXTHR: s_d.rxThr = regWdata;
        ufc_pkg::ADDR_STOP1: s_d.stop1 = regWdata;
        ufc_pkg::ADDR_STOP2: s_d.stop2 = regWdata;
        ufc_pkg::ADDR_RES1: s_d.res1 = regWdata;
        ufc_pkg::ADDR_RES2: s_d.res2 = regWdata;
        ufc_pkg::ADDR_IER:
          s_d.interrupt_enable_reg = gatedWrite(s_q.interrupt_enable_reg, regWdata, ufc_pkg::IER_ENH_MASK,
                               s_q.enhanced_feature_ctrl[ufc_pkg::EFR_ENH]);
        ufc_pkg::ADDR_ISR:
          s_d.interrupt_status_reg = gatedWrite(s_d.interrupt_status_reg, regWdata, ufc_pkg::ISR_ENH_MASK,
                               s_q.enhanced_feature_ctrl[ufc_pkg::EFR_ENH]);
        ufc_pkg::ADDR_FCR:
          s_d.fifo_control_reg = gatedWrite(s_q.fifo_control_reg, regWdata, ufc_pkg::FCR_ENH_MASK,
                               s_q.enhanced_feature_ctrl[ufc_pkg::EFR_ENH]);
        ufc_pkg::ADDR_MCR:
          s_d.modem_control_reg = gatedWrite(s_q.modem_control_reg, regWdata, ufc_pkg::MCR_ENH_MASK,
                               s_q.enhanced_feature_ctrl[ufc_pkg::EFR_ENH]);
        ufc_pkg::ADDR_MSR:
          s_d.modem_status_reg = gatedWrite(s_q.modem_status_reg, regWdata, ufc_pkg::MSR_ENH_MASK,
                               s_q.enhanced_feature_ctrl[ufc_pkg::EFR_ENH]);
        ufc_pkg::ADDR_FEATURE_CONTROL_REG: s_d.feature_control_reg = regWdata;
        default: s_d.rdata = s_d.rdata;
      endcase
    end

    // flow off wipes status and any half-seen pair
    if (s_d.enhanced_feature_ctrl[3:0] == 4'h0)
    begin
      s_d.fstat = 4'h0;
      s_d.rxPend = 1'b0;
      s_d.rxHold = 1'b0;
    end
  end

  always_ff @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic selDtr;
  logic flowSel;
  logic modemSel;
  assign selDtr = s_q.modem_control_reg[ufc_pkg::MCR_SEL_DTR];
  assign modemSel = selDtr ? dsrN : ctsN;
  // remote stop char also halts, as does a high modem input
  assign txHalt = (s_q.enhanced_feature_ctrl[ufc_pkg::EFR_AUTO_CTS] && modemSel) || s_q.rxHold;
  // auto only pulls high; software must have left it low
  // half-duplex: pending flow chars with empty tx keep receive direction
  assign flowSel = rs485 ? !(txBusy || (s_q.txLvl != 9'h000))
                         : (s_q.rtsAuto || !s_q.modem_control_reg[ufc_pkg::MCR_RTS_SW]);
  assign rtsN = selDtr ? 1'b1 : flowSel;
  assign dtrN = selDtr ? flowSel : 1'b1;

  assign txCtrlValid = (s_q.txc != ufc_pkg::TXC_IDLE);
  always_comb
  begin
    if (s_q.txc == ufc_pkg::TXC_SECOND)
      txCtrlChar = s_q.txcStop ? s_q.stop2 : s_q.res2;
    else if (txSel == ufc_pkg::SEL_SECOND)
      txCtrlChar = s_q.txcStop ? s_q.stop2 : s_q.res2;
    else
      txCtrlChar = s_q.txcStop ? s_q.stop1 : s_q.res1;
  end

  assign regRdata = s_q.rdata;
  assign txLowIrq = s_q.txLowLvl;
  assign rxTrigIrq = s_q.rxTrigLvl;
  assign rxCharStore = s_q.charStore;
  assign rxStopSeen = s_q.stopSeen;
  assign rxResumeSeen = s_q.resumeSeen;

endmodule : ufc_flow

`default_nettype wire

// ---- ufc_flow_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_props (
  // clock, reset and register port
  input wire logic sysClk,
  input wire logic resetn,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // fifo events and character path
  input wire logic txPush,
  input wire logic txPop,
  input wire logic rxPush,
  input wire logic rxPop,
  input wire logic rxCharValid,
  input wire logic rxCharStore,
  // modem lines and status outputs
  input wire logic ctsN,
  input wire logic rtsN,
  input wire logic txHalt,
  input wire logic txLowIrq,
  input wire logic rxTrigIrq
);
  // ------------------------------
  // shadow of the writable state
  // ------------------------------
  logic [7:0] efrQ, mcrQ, txThrQ, rxThrQ;
  logic fctrQ;
  logic [8:0] txCntQ, rxCntQ;
  always_ff @(posedge sysClk or negedge resetn)
    if (!resetn)
    begin
      {efrQ, mcrQ, txThrQ, rxThrQ, fctrQ} <= '0;
      txCntQ <= 9'h000;
      rxCntQ <= 9'h000;
    end
    else
    begin
      txCntQ <= txCntQ + 9'(txPush) - 9'(txPop);
      rxCntQ <= rxCntQ + 9'(rxPush) - 9'(rxPop);
      if (regWr)
      begin
        case (regAddr)
          ufc_pkg::ADDR_EFR: efrQ <= regWdata;
          ufc_pkg::ADDR_TXTHR: txThrQ <= regWdata;
          ufc_pkg::ADDR_RXTHR: rxThrQ <= regWdata;
          ufc_pkg::ADDR_FEATURE_CONTROL_REG: fctrQ <= regWdata[5];
          // high bits only move while the enhanced gate is open
          ufc_pkg::ADDR_MCR: mcrQ <= efrQ[4] ? regWdata : {mcrQ[7:5], regWdata[4:0]};
          default: ;
        endcase
      end
    end
  wire logic [7:0] txLvl = txCntQ[8] ? 8'hff : txCntQ[7:0];
  wire logic txLow = txCntQ < {1'b0, txThrQ};
  wire logic rxTrig = rxCntQ >= {1'b0, rxThrQ};
  default clocking cb @(posedge sysClk);
  endclocking
  default disable iff (!resetn);
  AST_CTS_HALT: assert property (efrQ[7] && !mcrQ[2] && ctsN |-> txHalt)
    else $error("cts high did not halt");
  AST_SW_RTS: assert property (!efrQ[6] && !fctrQ && !mcrQ[2] |-> rtsN == !mcrQ[1])
    else $error("rts not software driven");
  AST_MCR_GATE: assert property (regRd && regAddr == ufc_pkg::ADDR_MCR |=>
    regRdata[7:5] == $past(mcrQ[7:5])) else $error("gated bits wrong");
  AST_TX_LVL: assert property (regRd && regAddr == ufc_pkg::ADDR_TXLVL |=>
    regRdata == $past(txLvl)) else $error("tx level wrong");
  AST_TX_LOW: assert property ($past(resetn) && $stable(txLow) |-> txLowIrq == txLow)
    else $error("tx low flag wrong");
  AST_RX_TRIG: assert property ($past(resetn) && $stable(rxTrig) |-> rxTrigIrq == rxTrig)
    else $error("rx trigger flag wrong");
  AST_FST_RSV: assert property (regRd && regAddr == ufc_pkg::ADDR_FSTAT |=>
    regRdata[7:4] == 4'h0) else $error("reserved status bits set");
  AST_STORE: assert property (rxCharStore |-> $past(rxCharValid))
    else $error("store without character");
endmodule : ufc_flow_props
bind ufc_flow ufc_flow_props chk (.sysClk, .resetn, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .txPush, .txPop, .rxPush, .rxPop, .rxCharValid, .rxCharStore, .ctsN, .rtsN,
  .txHalt, .txLowIrq, .rxTrigIrq);
`default_nettype wire

// ---- ufc_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufc_peer (
  // clock and reset
  input wire logic sysClk,
  input wire logic resetn,
  // modem lines toward the block
  output logic ctsN,
  output logic dsrN,
  // received characters
  output logic rxCharValid,
  output logic [7:0] rxChar,
  input wire logic rxCharStore,
  // control characters sent by the block
  input wire logic txCtrlValid,
  input wire logic [7:0] txCtrlChar,
  output logic txCtrlReady
);
  // ------------------------------
  // remote line model
  // ------------------------------
  logic slow = 1'b0;
  logic tog = 1'b0;
  int stores = 0;
  logic [7:0] got[$];
  initial
  begin
    ctsN = 1'b0;
    dsrN = 1'b0;
    rxCharValid = 1'b0;
    rxChar = 8'h5a;
  end
  // slow mode accepts only every other cycle
  assign txCtrlReady = !slow || tog;
  always @(posedge sysClk)
  begin
    tog <= !tog;
    if (txCtrlValid && txCtrlReady)
      got.push_back(txCtrlChar);
    if (rxCharStore)
      stores++;
  end
  task automatic send(input logic [7:0] c);
    @(posedge sysClk);
    rxChar <= c;
    rxCharValid <= 1'b1;
    @(posedge sysClk);
    rxCharValid <= 1'b0;
    // stale data would hide a late sample
    rxChar <= ~c;
  endtask : send
endmodule : ufc_peer
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------
  // stimulus, checks and scenarios
  // ------------------------------
  logic sysClk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] fifoEv = 4'h0;
  logic txFlowNeedStop = 1'b0;
  logic txFlowNeedResume = 1'b0;
  logic [7:0] regRdata, rxChar, txCtrlChar;
  logic rxCharValid, rxCharStore, txCtrlValid, txCtrlReady, txHalt;
  logic ctsN, dsrN, rtsN, dtrN, txLowIrq, rxTrigIrq;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  always #5 sysClk = ~sysClk;
  ufc_flow uut (.sysClk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .txPush(fifoEv[0]), .txPop(fifoEv[1]), .rxPush(fifoEv[2]), .rxPop(fifoEv[3]),
    .rxCharValid, .rxChar, .rxCharStore, .txFlowNeedStop, .txFlowNeedResume, .txCtrlValid,
    .txCtrlChar, .txCtrlReady, .txBusy(1'b0), .txHalt, .ctsN, .dsrN, .rtsN, .dtrN,
    .txLowIrq, .rxTrigIrq, .rxStopSeen(), .rxResumeSeen());
  ufc_peer peer (.sysClk, .resetn, .ctsN, .dsrN, .rxCharValid, .rxChar, .rxCharStore,
    .txCtrlValid, .txCtrlChar, .txCtrlReady);
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sysClk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdm(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sysClk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sysClk);
    regRd <= 1'b0;
    #1;
    chk(regRdata & m, e);
  endtask : rdm
  task automatic ev(input logic [3:0] m, input int n);
    @(posedge sysClk);
    fifoEv <= m;
    repeat (n) @(posedge sysClk);
    fifoEv <= 4'h0;
    repeat (2) @(posedge sysClk);
    #1;
  endtask : ev
  task automatic ctl(input logic st, input logic [1:0] s);
    peer.got.delete();
    @(posedge sysClk);
    {txFlowNeedStop, txFlowNeedResume} <= {st, !st};
    @(posedge sysClk);
    {txFlowNeedStop, txFlowNeedResume} <= 2'b00;
    ev(4'h0, 10);
    if (s[1]) chk(peer.got.pop_front(), st ? 8'h13 : 8'h11);
    if (s[0]) chk(peer.got.pop_front(), st ? 8'h93 : 8'h91);
    chk(8'(peer.got.size()), 8'h00);
    rdm(ufc_pkg::ADDR_FSTAT, 8'hff, st ? 8'h04 : 8'h08);
    rdm(ufc_pkg::ADDR_FSTAT, 8'hff, 8'h00);
  endtask : ctl
  task automatic rxc(input logic [7:0] c, input logic [7:0] e);
    peer.send(c);
    rdm(ufc_pkg::ADDR_FSTAT, 8'hff, e);
  endtask : rxc
  task automatic t_reset;
    logic [4:0] regs[8] = '{ufc_pkg::ADDR_EFR, ufc_pkg::ADDR_TXLVL, ufc_pkg::ADDR_RXLVL,
      ufc_pkg::ADDR_FSTAT, ufc_pkg::ADDR_IER, ufc_pkg::ADDR_MCR, ufc_pkg::ADDR_MSR, 5'h1f};
    foreach (regs[i]) rdm(regs[i], 8'hff, 8'h00);
    chk(8'({rtsN, dtrN}), 8'h03);
  endtask : t_reset
  task automatic t_gate;
    wr(ufc_pkg::ADDR_MCR, 8'he0);
    rdm(ufc_pkg::ADDR_MCR, 8'he0, 8'h00);
    wr(ufc_pkg::ADDR_EFR, 8'h10);
    wr(ufc_pkg::ADDR_MCR, 8'he0);
    wr(ufc_pkg::ADDR_IER, 8'he0);
    wr(ufc_pkg::ADDR_EFR, 8'h00);
    wr(ufc_pkg::ADDR_MCR, 8'h00);
    wr(ufc_pkg::ADDR_IER, 8'h00);
    rdm(ufc_pkg::ADDR_MCR, 8'he0, 8'he0);
    rdm(ufc_pkg::ADDR_IER, 8'he0, 8'he0);
    wr(ufc_pkg::ADDR_EFR, 8'h10);
    wr(ufc_pkg::ADDR_MCR, 8'h00);
    wr(ufc_pkg::ADDR_IER, 8'h00);
    wr(ufc_pkg::ADDR_EFR, 8'h00);
  endtask : t_gate
  task automatic t_levels;
    wr(ufc_pkg::ADDR_TXTHR, 8'h05);
    wr(ufc_pkg::ADDR_RXTHR, 8'h04);
    ev(4'h5, 3);
    chk(8'({txLowIrq, rxTrigIrq}), 8'h02);
    rdm(ufc_pkg::ADDR_TXLVL, 8'hff, 8'h03);
    ev(4'h5, 2);
    chk(8'({txLowIrq, rxTrigIrq}), 8'h01);
    ev(4'h5, 251);
    rdm(ufc_pkg::ADDR_TXLVL, 8'hff, 8'hff);
    rdm(ufc_pkg::ADDR_RXLVL, 8'hff, 8'hff);
    ev(4'ha, 255);
    rdm(ufc_pkg::ADDR_RXLVL, 8'hff, 8'h01);
    chk(8'({txLowIrq, rxTrigIrq}), 8'h02);
    ev(4'ha, 1);
  endtask : t_levels
  task automatic t_modem;
    wr(ufc_pkg::ADDR_EFR, 8'h80);
    peer.ctsN <= 1'b1;
    ev(4'h0, 1);
    chk(8'(txHalt), 8'h01);
    peer.ctsN <= 1'b0;
    ev(4'h0, 1);
    chk(8'(txHalt), 8'h00);
    wr(ufc_pkg::ADDR_MCR, 8'h04);
    peer.dsrN <= 1'b1;
    ev(4'h0, 1);
    chk(8'(txHalt), 8'h01);
    peer.dsrN <= 1'b0;
    wr(ufc_pkg::ADDR_EFR, 8'h00);
    wr(ufc_pkg::ADDR_MCR, 8'h02);
    chk(8'(rtsN), 8'h00);
    wr(ufc_pkg::ADDR_RXTHR, 8'h08);
    wr(ufc_pkg::ADDR_EFR, 8'h40);
    ev(4'h4, 16);
    chk(8'({rtsN, rxTrigIrq}), 8'h03);
    ev(4'h8, 16);
    chk(8'({rtsN, rxTrigIrq}), 8'h00);
    wr(ufc_pkg::ADDR_EFR, 8'h00);
    wr(ufc_pkg::ADDR_MCR, 8'h00);
    chk(8'(rtsN), 8'h01);
  endtask : t_modem
  task automatic t_txflow;
    logic [1:0] sel[3] = '{2'b10, 2'b01, 2'b11};
    wr(ufc_pkg::ADDR_STOP1, 8'h13);
    wr(ufc_pkg::ADDR_STOP2, 8'h93);
    wr(ufc_pkg::ADDR_RES1, 8'h11);
    wr(ufc_pkg::ADDR_RES2, 8'h91);
    foreach (sel[i])
    begin
      wr(ufc_pkg::ADDR_EFR, 8'h00);
      wr(ufc_pkg::ADDR_EFR, {4'h0, sel[i], 2'b00});
      peer.slow = i[0];
      ctl(1'b1, sel[i]);
      ctl(1'b0, sel[i]);
    end
    wr(ufc_pkg::ADDR_EFR, 8'h00);
  endtask : t_txflow
  task automatic t_special;
    int n;
    wr(ufc_pkg::ADDR_EFR, 8'h22);
    n = peer.stores;
    peer.send(8'h93);
    rdm(ufc_pkg::ADDR_ISR, 8'h10, 8'h10);
    chk(8'(peer.stores - n), 8'h01);
    wr(ufc_pkg::ADDR_EFR, 8'h00);
    wr(ufc_pkg::ADDR_EFR, 8'h21);
    n = peer.stores;
    peer.send(8'h93);
    rdm(ufc_pkg::ADDR_ISR, 8'h30, 8'h30);
    chk(8'(peer.stores - n), 8'h00);
    wr(ufc_pkg::ADDR_EFR, 8'h00);
  endtask : t_special
  task automatic t_rxflow;
    logic [1:0] sel[2] = '{2'b10, 2'b01};
    rxc(8'h13, 8'h00);
    foreach (sel[i])
    begin
      wr(ufc_pkg::ADDR_EFR, 8'h00);
      wr(ufc_pkg::ADDR_EFR, {6'h00, sel[i]});
      rxc(sel[i][1] ? 8'h13 : 8'h93, 8'h01);
      rxc(sel[i][1] ? 8'h11 : 8'h91, 8'h02);
    end
    peer.send(8'h93);
    wr(ufc_pkg::ADDR_EFR, 8'h00);
    rdm(ufc_pkg::ADDR_FSTAT, 8'hff, 8'h00);
  endtask : t_rxflow
  task automatic report_and_stop;
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (10) @(posedge sysClk);
    resetn <= 1'b1;
    t_reset();
    t_gate();
    t_levels();
    t_modem();
    t_txflow();
    t_special();
    t_rxflow();
    report_and_stop();
  end
  // the whole run needs under a thousand cycles
  always @(posedge sysClk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end
endmodule : tb_top
`default_nettype wire
